/* dv/rsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rsc_host_model
  import rsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic [6:0] count_i,
  input wire logic [7:0] data_i,
  output rsc_strobe_type strobe_o,
  output logic cs_n_o,
  output logic read_o
);
  logic [7:0] got_q[$];

  // ****************************************************************
  // Idle pins at start
  // ****************************************************************
  initial begin
    strobe_o = '0;
    cs_n_o = 1'b1;
    read_o = 1'b0;
  end

  // One-cycle strobe, launched just after an edge
  task automatic strobe(input rsc_strobe_type s);
    @(posedge clk_i);
    #2 strobe_o = s;
    @(posedge clk_i);
    #2 strobe_o = '0;
  endtask

  // Chip select level, then one cycle
  task automatic select(input logic lvl);
    cs_n_o = lvl;
    @(posedge clk_i);
    #2;
  endtask

  // Pop one byte, never past empty
  task automatic pop();
    @(posedge clk_i);
    #2;
    if (count_i != '0) begin
      read_o = 1'b1;
      @(posedge clk_i);
      #2 read_o = 1'b0;
      got_q.push_back(data_i);
    end
  endtask

  // Poll fill count until stable, then take all but one byte
  task automatic drain_burst(output int n);
    int prev;
    prev = -1;
    n = int'(count_i);
    while (n != prev) begin
      prev = n;
      @(posedge clk_i);
      #2 n = int'(count_i);
    end
    repeat (n - 1) pop();
  endtask
endmodule
`default_nettype wire

/* dv/rsc_radio_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rsc_radio_ctrl_tb
  import rsc_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n;
  rsc_cfg_type cfg;
  rsc_strobe_type strobe;
  logic cs_n, rd, pkt, csv, carrier, sym, bv, flush;
  logic [7:0] rx_byte, fdata, status;
  logic [3:0] thr_sel;
  logic [5:0] outsel;
  logic [6:0] count;
  logic [2:0] state;
  logic reg_on, xosc_on, rx_act, cal_busy, ovf, gpo;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  always #12.5 clk = ~clk;

  rsc_radio_ctrl #(.CAL_FULL_SHORT(40), .CAL_FULL_LONG(50), .FIFO_DEPTH(64)) dut (
    .CLK_I(clk), .ARST_N_I(arst_n), .CHIP_SELECT_LOW_N_I(cs_n), .STROBE_I(strobe),
    .CFG_I(cfg), .FILL_THRESHOLD_SELECT_I(thr_sel), .OUTPUT_SELECT_I(outsel),
    .PACKET_OK_I(pkt), .CS_SAMPLE_VALID_I(csv), .CARRIER_I(carrier),
    .SYMBOL_TICK_I(sym), .RX_BYTE_VALID_I(bv), .RX_BYTE_I(rx_byte), .FIFO_READ_I(rd),
    .FIFO_FLUSH_I(flush), .FIFO_DATA_O(fdata), .RECEIVE_FILL_COUNT_O(count),
    .STATUS_BYTE_O(status), .CONTROLLER_STATE_READBACK_O(state), .REGULATOR_ON_O(reg_on),
    .XOSC_ON_O(xosc_on), .RX_ACTIVE_O(rx_act), .CAL_BUSY_O(cal_busy), .OVERFLOW_O(ovf),
    .GENERAL_OUTPUT_PIN_O(gpo));

  rsc_host_model host (
    .clk_i(clk), .count_i(count), .data_i(fdata), .strobe_o(strobe), .cs_n_o(cs_n),
    .read_o(rd));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #2;
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (8) step();
    arst_n = 1'b1;
  endtask

  // Cycles spent in one state, bounded
  task automatic dur(input logic [2:0] st, output int c);
    c = 0;
    while (state === st && c < 30000) begin
      c++;
      step();
    end
  endtask

  task automatic enter_rx(input int exp);
    host.strobe('{rx: 1'b1, default: 1'b0});
    dur(RSC_SETTLE, n);
    chk("settle", n[15:0], exp[15:0]);
    chk("rx state", {13'h0, state}, {13'h0, RSC_RX});
  endtask

  task automatic pk();
    step();
    pkt = 1'b1;
    step();
    pkt = 1'b0;
  endtask

  task automatic cs_smp(input logic c);
    step();
    carrier = c;
    csv = 1'b1;
    step();
    csv = 1'b0;
  endtask

  task automatic wr_n(input int k, input logic [7:0] base);
    bv = 1'b1;
    for (int i = 0; i < k; i++) begin
      rx_byte = base + 8'(i);
      step();
    end
    bv = 1'b0;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    cfg = '0;
    cfg.synth_test = 8'h09;
    cfg.cp_cal = 2'h2;
    pkt = 1'b0;
    csv = 1'b0;
    carrier = 1'b0;
    sym = 1'b0;
    bv = 1'b0;
    flush = 1'b0;
    rx_byte = 8'h00;
    thr_sel = 4'h1;
    outsel = OUTSEL_THR;
    do_reset();
    chk("reset state", {13'h0, state}, {13'h0, RSC_IDLE});
    chk("reset status", {8'h0, status}, 16'h0010);
    chk("reset power", {14'h0, reg_on, xosc_on}, 16'h0003);
    enter_rx(1953);
    chk("rx active", {15'h0, rx_act}, 16'h0001);
    cfg.autocal = AUTOCAL_TO_IDLE;
    host.strobe('{idle: 1'b1, default: 1'b0});
    chk("forced idle", {13'h0, state}, {13'h0, RSC_IDLE});
    cfg.autocal = AUTOCAL_TO_RX;
    enter_rx(1953 + 40);
    cfg.after_pkt = AFTER_PKT_RX;
    pk();
    chk("stay rx", {13'h0, state}, {13'h0, RSC_RX});
    cfg.after_pkt = 2'h0;
    cfg.autocal = AUTOCAL_OFF;
    pk();
    dur(RSC_RXOFF, n);
    chk("rx to idle", n[15:0], 16'd2);
    // Early exit with charge pump skipped, long synth setting
    cfg.autocal = AUTOCAL_TO_IDLE;
    cfg.cp_cal = CP_CAL_SKIP;
    cfg.synth_test = SYNTH_TEST_LONG;
    enter_rx(1953);
    cfg.early_exit = 1'b1;
    cfg.after_pkt = AFTER_PKT_RX;
    cs_smp(1'b1);
    chk("carrier keeps rx", {13'h0, state}, {13'h0, RSC_RX});
    cs_smp(1'b0);
    dur(RSC_RXOFF, n);
    chk("early exit cal", n[15:0], 16'd4075);
    chk("early exit idle", {13'h0, state}, {13'h0, RSC_IDLE});
    // On-off keying waits eight symbols
    cfg.autocal = AUTOCAL_OFF;
    cfg.ook = 1'b1;
    enter_rx(1953);
    cs_smp(1'b0);
    chk("ook early", {13'h0, state}, {13'h0, RSC_RX});
    sym = 1'b1;
    repeat (7) step();
    sym = 1'b0;
    cs_smp(1'b0);
    chk("ook seven", {13'h0, state}, {13'h0, RSC_RX});
    sym = 1'b1;
    step();
    sym = 1'b0;
    cs_smp(1'b0);
    dur(RSC_RXOFF, n);
    chk("ook exit", n[15:0], 16'd2);
    // Every fourth automatic exit calibrates
    cfg = '0;
    cfg.synth_test = 8'h09;
    cfg.cp_cal = 2'h2;
    cfg.autocal = AUTOCAL_EVERY4;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      enter_rx(1953);
      pk();
      dur(RSC_RXOFF, n);
      chk("every4", n[15:0], (i == 3) ? 16'd42 : 16'd2);
    end
    // Manual calibration, both charge pump choices
    for (int i = 0; i < 2; i++) begin
      cfg.cp_cal = i ? CP_CAL_SKIP : 2'h2;
      cfg.synth_test = i ? 8'h09 : SYNTH_TEST_LONG;
      host.strobe('{cal: 1'b1, default: 1'b0});
      chk("cal busy", {15'h0, cal_busy}, 16'h0001);
      dur(RSC_CAL, n);
      chk("manual cal", n[15:0], i ? 16'd4047 : 16'd333);
    end
    // Power down only from idle, then sleep and wake
    host.select(1'b0);
    enter_rx(1953);
    host.strobe('{pwd: 1'b1, default: 1'b0});
    pk();
    host.select(1'b1);
    repeat (6) step();
    chk("pwd ignored", {13'h0, state}, {13'h0, RSC_IDLE});
    host.select(1'b0);
    step();
    host.strobe('{pwd: 1'b1, default: 1'b0});
    host.select(1'b1);
    repeat (3) step();
    chk("sleep", {12'h0, state, reg_on}, {12'h0, RSC_SLEEP, 1'b0});
    host.select(1'b0);
    repeat (4) step();
    chk("wake", {12'h0, state, reg_on}, {12'h0, RSC_IDLE, 1'b1});
    // Crystal off from idle, woken the same way
    host.strobe('{xoff: 1'b1, default: 1'b0});
    host.select(1'b1);
    repeat (3) step();
    chk("xoff", {12'h0, state, xosc_on}, {12'h0, RSC_XOFF, 1'b0});
    host.select(1'b0);
    repeat (4) step();
    chk("xoff wake", {12'h0, state, xosc_on}, {12'h0, RSC_IDLE, 1'b1});
    // Receive FIFO threshold, order, overflow
    wr_n(7, 8'ha0);
    step();
    chk("below thr", {8'h0, count, gpo}, 16'h000e);
    wr_n(1, 8'ha7);
    step();
    chk("at thr", {8'h0, count, gpo}, 16'h0011);
    chk("status fill", {12'h0, status[3:0]}, 16'h0008);
    host.drain_burst(n);
    step();
    chk("drained", {8'h0, count, gpo}, 16'h0002);
    for (int i = 0; i < 7; i++) begin
      chk("fifo data", {8'h0, host.got_q[i]}, 16'h00a0 + 16'(i));
    end
    thr_sel = 4'hf;
    wr_n(63, 8'h10);
    step();
    chk("full thr", {8'h0, count, gpo}, 16'h0081);
    outsel = OUTSEL_OVF;
    wr_n(1, 8'h55);
    repeat (3) step();
    chk("overflow", {7'h0, count, ovf, gpo}, 16'h0103);
    flush = 1'b1;
    step();
    flush = 1'b0;
    step();
    chk("flushed", {7'h0, count, ovf, gpo}, 16'h0000);
    // Packet end holds the pin until the FIFO is empty
    outsel = OUTSEL_THR_EOP;
    wr_n(2, 8'h20);
    repeat (2) step();
    chk("eop before", {8'h0, count, gpo}, 16'h0004);
    pk();
    repeat (2) step();
    chk("eop held", {8'h0, count, gpo}, 16'h0005);
    host.pop();
    host.pop();
    repeat (2) step();
    chk("eop empty", {8'h0, count, gpo}, 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* rtl/rsc_pkg.sv */
package rsc_pkg;

  // ****************************************************************
  // States, strobes and configuration
  // ****************************************************************
  typedef enum logic [2:0] {
    RSC_SLEEP = 3'h0,
    RSC_IDLE = 3'h1,
    RSC_XOFF = 3'h2,
    RSC_SETTLE = 3'h3,
    RSC_RX = 3'h4,
    RSC_RXOFF = 3'h5,
    RSC_CAL = 3'h6
  } rsc_state_type;

  typedef struct packed {
    logic rx;
    logic idle;
    logic cal;
    logic pwd;
    logic xoff;
  } rsc_strobe_type;

  typedef struct packed {
    logic [1:0] autocal;
    logic [1:0] after_pkt;
    logic early_exit;
    logic ook;
    logic [1:0] cp_cal;
    logic [7:0] synth_test;
  } rsc_cfg_type;

  // ****************************************************************
  // Field encodings
  // ****************************************************************
  localparam logic [1:0] AUTOCAL_OFF = 2'h0;
  localparam logic [1:0] AUTOCAL_TO_RX = 2'h1;
  localparam logic [1:0] AUTOCAL_TO_IDLE = 2'h2;
  localparam logic [1:0] AUTOCAL_EVERY4 = 2'h3;
  localparam logic [1:0] AFTER_PKT_RX = 2'h3;
  localparam logic [1:0] CP_CAL_SKIP = 2'h0;
  localparam logic [7:0] SYNTH_TEST_LONG = 8'h0b;
  localparam logic [5:0] OUTSEL_THR = 6'h00;
  localparam logic [5:0] OUTSEL_THR_EOP = 6'h01;
  localparam logic [5:0] OUTSEL_OVF = 6'h04;

  // ****************************************************************
  // Cycle counts in oscillator cycles
  // ****************************************************************
  localparam int TMR_W = 16;
  localparam logic [15:0] CYC_IDLE_TO_RX = 16'h07a1;
  localparam logic [15:0] CYC_RX_TO_IDLE = 16'h0002;
  localparam logic [15:0] CYC_MANUAL_CAL = 16'h011b;
  localparam logic [15:0] CYC_CAL_SKIP_SHORT = 16'h0eb4;
  localparam logic [15:0] CYC_CAL_SKIP_LONG = 16'h0fe9;
  localparam int CYC_CAL_FULL_SHORT_DEF = 32'h0000484a;
  localparam int CYC_CAL_FULL_LONG_DEF = 32'h0000497f;
  localparam logic [3:0] OOK_CS_SYMBOLS = 4'h8;
  localparam logic [1:0] EXIT_CNT_WRAP = 2'h3;

  // ****************************************************************
  // Receive FIFO
  // ****************************************************************
  localparam int FIFO_DEPTH_DEF = 64;
  localparam int FILL_THRESHOLD_SELECT_STEP = 4;

endpackage

/* rtl/rsc_radio_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Power-down then chip select high: sleep, regulator off
// - Chip select low in sleep wakes to idle
// - Receive strobe starts receive mode
// - Auto-calibration select plus manual calibrate strobe
// - Idle strobe exit from receive skips calibration
// - Receive holds until packet or no-carrier exit
// - After packet: idle, or stay in receive on 11
// - Idle strobe forces idle from anywhere
// - Early exit on first no-carrier sample
// - Under on-off keying wait eight symbols
// - No-carrier exit always returns to idle
// - Idle to receive takes 1953 cycles
// - Receive to idle takes 2 cycles
// - Calibration adds time; manual is 283 plus
// - Charge pump skipped: 3764 or 4073 cycles
// - Charge pump on: 18506 or 18815 cycles
// - 64-byte receive FIFO with overflow detection
// - Status byte carries fill level
// - Host never empties FIFO before packet end
// - Threshold is four times select plus four
// - Threshold signal when count at or above
// - Threshold signal drops below threshold
// - Overflow indication holds until flush
// - Calibrate strobe in idle starts calibration
// - Crystal-off and power-down only from idle
module rsc_radio_ctrl
  import rsc_pkg::*;
#(
  parameter int CAL_FULL_SHORT = CYC_CAL_FULL_SHORT_DEF,
  parameter int CAL_FULL_LONG = CYC_CAL_FULL_LONG_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic CHIP_SELECT_LOW_N_I,
  input wire rsc_strobe_type STROBE_I,
  input wire rsc_cfg_type CFG_I,
  input wire logic [3:0] FILL_THRESHOLD_SELECT_I,
  input wire logic [5:0] OUTPUT_SELECT_I,
  input wire logic PACKET_OK_I,
  input wire logic CS_SAMPLE_VALID_I,
  input wire logic CARRIER_I,
  input wire logic SYMBOL_TICK_I,
  input wire logic RX_BYTE_VALID_I,
  input wire logic [7:0] RX_BYTE_I,
  input wire logic FIFO_READ_I,
  input wire logic FIFO_FLUSH_I,
  output logic [7:0] FIFO_DATA_O,
  output logic [$clog2(FIFO_DEPTH):0] RECEIVE_FILL_COUNT_O,
  output logic [7:0] STATUS_BYTE_O,
  output logic [2:0] CONTROLLER_STATE_READBACK_O,
  output logic REGULATOR_ON_O,
  output logic XOSC_ON_O,
  output logic RX_ACTIVE_O,
  output logic CAL_BUSY_O,
  output logic OVERFLOW_O,
  output logic GENERAL_OUTPUT_PIN_O
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (CAL_FULL_SHORT < 1 || CAL_FULL_LONG < 1 || CAL_FULL_LONG > 32'h0000f000
      || CAL_FULL_SHORT > 32'h0000f000) begin : g_bad_cal
    $error("calibration counts must fit the transition timer");
  end

  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  rsc_state_type state_reg;
  logic [TMR_W-1:0] timer_reg;
  logic [TMR_W-1:0] cal_cycles;
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_prev_reg;
  logic cs_rise;
  logic pend_sleep_reg;
  logic pend_xoff_reg;
  logic [3:0] sym_cnt_reg;
  logic [1:0] exit_cnt_reg;
  logic early_fail;
  logic pkt_to_idle;
  logic auto_exit;
  logic cal_on_exit;
  logic eop_flag_reg;
  logic gpo_reg;
  logic [CW-1:0] fill_count;
  logic fill_threshold_select;
  logic fifo_ovf;
  logic fifo_empty;

  // ****************************************************************
  // Chip select synchroniser
  // ****************************************************************
  // Pin crosses from the host, two flops before use
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= CHIP_SELECT_LOW_N_I;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  assign cs_rise = cs_sync_reg && !cs_prev_reg;

  // ****************************************************************
  // Event decode
  // ****************************************************************
  // Calibration length from charge pump and synth test settings
  always_comb begin
    if (CFG_I.cp_cal == CP_CAL_SKIP) begin
      cal_cycles = (CFG_I.synth_test == SYNTH_TEST_LONG) ?
                   CYC_CAL_SKIP_LONG : CYC_CAL_SKIP_SHORT;
    end else begin
      cal_cycles = (CFG_I.synth_test == SYNTH_TEST_LONG) ?
                   TMR_W'(CAL_FULL_LONG) : TMR_W'(CAL_FULL_SHORT);
    end
  end

  // No-carrier exit, held off for eight symbols under on-off keying
  assign early_fail = CFG_I.early_exit && CS_SAMPLE_VALID_I && !CARRIER_I
                      && (!CFG_I.ook || sym_cnt_reg == OOK_CS_SYMBOLS);
  assign pkt_to_idle = PACKET_OK_I && (CFG_I.after_pkt != AFTER_PKT_RX);
  assign auto_exit = (state_reg == RSC_RX) && !STROBE_I.idle
                     && (early_fail || pkt_to_idle);
  assign cal_on_exit = (CFG_I.autocal == AUTOCAL_TO_IDLE)
                       || (CFG_I.autocal == AUTOCAL_EVERY4
                           && exit_cnt_reg == EXIT_CNT_WRAP);

  // ****************************************************************
  // Main state machine and transition timer
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= RSC_IDLE;
      timer_reg <= '0;
    end else if (STROBE_I.idle) begin
      state_reg <= RSC_IDLE;
      timer_reg <= '0;
    end else begin
      case (state_reg)
        RSC_SLEEP, RSC_XOFF: begin
          if (!cs_sync_reg) begin
            state_reg <= RSC_IDLE;
          end
        end
        RSC_IDLE: begin
          if (cs_rise && pend_sleep_reg) begin
            state_reg <= RSC_SLEEP;
          end else if (cs_rise && pend_xoff_reg) begin
            state_reg <= RSC_XOFF;
          end else if (STROBE_I.rx) begin
            state_reg <= RSC_SETTLE;
            timer_reg <= (CFG_I.autocal == AUTOCAL_TO_RX) ?
                         CYC_IDLE_TO_RX + cal_cycles : CYC_IDLE_TO_RX;
          end else if (STROBE_I.cal) begin
            state_reg <= RSC_CAL;
            timer_reg <= CYC_MANUAL_CAL + cal_cycles;
          end
        end
        RSC_SETTLE: begin
          if (timer_reg == TMR_W'(1)) begin
            state_reg <= RSC_RX;
          end
          timer_reg <= timer_reg - TMR_W'(1);
        end
        RSC_RX: begin
          if (auto_exit) begin
            state_reg <= RSC_RXOFF;
            timer_reg <= cal_on_exit ?
                         CYC_RX_TO_IDLE + cal_cycles : CYC_RX_TO_IDLE;
          end
        end
        RSC_RXOFF, RSC_CAL: begin
          if (timer_reg == TMR_W'(1)) begin
            state_reg <= RSC_IDLE;
          end
          timer_reg <= timer_reg - TMR_W'(1);
        end
        default: begin
          state_reg <= RSC_IDLE;
          timer_reg <= '0;
        end
      endcase
    end
  end

  // Power-down and crystal-off wait in idle for chip select release
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pend_sleep_reg <= 1'b0;
      pend_xoff_reg <= 1'b0;
    end else if (state_reg != RSC_IDLE || STROBE_I.idle) begin
      pend_sleep_reg <= 1'b0;
      pend_xoff_reg <= 1'b0;
    end else begin
      // A new strobe wins over a same-cycle release
      pend_sleep_reg <= STROBE_I.pwd || (pend_sleep_reg && !cs_rise);
      pend_xoff_reg <= STROBE_I.xoff || (pend_xoff_reg && !cs_rise);
    end
  end

  // Symbols since receive search started
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sym_cnt_reg <= 4'h0;
    end else if (state_reg != RSC_RX || PACKET_OK_I) begin
      sym_cnt_reg <= 4'h0;
    end else if (SYMBOL_TICK_I && sym_cnt_reg != OOK_CS_SYMBOLS) begin
      sym_cnt_reg <= sym_cnt_reg + 4'h1;
    end
  end

  // Automatic receive exits, modulo four
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      exit_cnt_reg <= 2'h0;
    end else if (auto_exit) begin
      exit_cnt_reg <= exit_cnt_reg + 2'h1;
    end
  end

  // ****************************************************************
  // Receive FIFO and output pin
  // ****************************************************************
  rsc_rx_fifo #(
    .DEPTH(FIFO_DEPTH),
    .CW(CW)
  ) u_fifo (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .wr_valid_i(RX_BYTE_VALID_I),
    .wr_data_i(RX_BYTE_I),
    .rd_en_i(FIFO_READ_I),
    .flush_i(FIFO_FLUSH_I),
    .thr_sel_i(FILL_THRESHOLD_SELECT_I),
    .rd_data_o(FIFO_DATA_O),
    .count_o(fill_count),
    .thr_o(fill_threshold_select),
    .ovf_o(fifo_ovf),
    .empty_o(fifo_empty)
  );

  // Threshold or end of packet, held until the FIFO is empty
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      eop_flag_reg <= 1'b0;
    end else if (fill_threshold_select || PACKET_OK_I) begin
      eop_flag_reg <= 1'b1;
    end else if (fifo_empty) begin
      eop_flag_reg <= 1'b0;
    end
  end

  // Selected signal onto the general output pin
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gpo_reg <= 1'b0;
    end else begin
      case (OUTPUT_SELECT_I)
        OUTSEL_THR: gpo_reg <= fill_threshold_select;
        OUTSEL_THR_EOP: gpo_reg <= eop_flag_reg || fill_threshold_select;
        OUTSEL_OVF: gpo_reg <= fifo_ovf;
        default: gpo_reg <= 1'b0;
      endcase
    end
  end

  assign RECEIVE_FILL_COUNT_O = fill_count;
  // Not-ready flag, state, saturated fill level
  assign STATUS_BYTE_O = {!XOSC_ON_O, state_reg,
                          (fill_count > CW'(15)) ? 4'hf : fill_count[3:0]};
  assign CONTROLLER_STATE_READBACK_O = state_reg;
  assign REGULATOR_ON_O = (state_reg != RSC_SLEEP);
  assign XOSC_ON_O = (state_reg != RSC_SLEEP) && (state_reg != RSC_XOFF);
  assign RX_ACTIVE_O = (state_reg == RSC_RX);
  assign CAL_BUSY_O = (state_reg == RSC_CAL);
  assign OVERFLOW_O = fifo_ovf;
  assign GENERAL_OUTPUT_PIN_O = gpo_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_rx_nocal;
    state_reg == RSC_IDLE && STROBE_I.rx && !STROBE_I.idle && !cs_rise
      && CFG_I.autocal != AUTOCAL_TO_RX;
  endsequence

  sequence s_early_nocal;
    state_reg == RSC_RX && early_fail && !STROBE_I.idle && !cal_on_exit;
  endsequence

  a_sleep_entry: assert property (state_reg == RSC_IDLE && pend_sleep_reg && cs_rise
    && !STROBE_I.idle |=> state_reg == RSC_SLEEP && !REGULATOR_ON_O)
    else $error("no sleep after power-down and release");
  a_wake_idle: assert property (state_reg == RSC_SLEEP && !cs_sync_reg
    |=> state_reg == RSC_IDLE && REGULATOR_ON_O)
    else $error("chip select low did not wake");
  a_idle_force: assert property (STROBE_I.idle |=> state_reg == RSC_IDLE)
    else $error("idle strobe did not force idle");
  a_cal_skip: assert property (state_reg == RSC_RX && STROBE_I.idle
    |=> state_reg == RSC_IDLE ##1 !CAL_BUSY_O)
    else $error("calibration after idle strobe");
  a_settle_load: assert property (s_rx_nocal |=> state_reg == RSC_SETTLE
    && timer_reg == CYC_IDLE_TO_RX)
    else $error("idle to receive timer wrong");
  a_settle_end: assert property (state_reg == RSC_SETTLE && timer_reg == TMR_W'(1)
    && !STROBE_I.idle |=> state_reg == RSC_RX)
    else $error("receive not reached at timer end");
  a_off_time: assert property (s_early_nocal |=> state_reg == RSC_RXOFF
    ##[1:2] state_reg == RSC_IDLE)
    else $error("receive to idle too slow");
  a_pkt_stay: assert property (state_reg == RSC_RX && PACKET_OK_I
    && CFG_I.after_pkt == AFTER_PKT_RX && !early_fail && !STROBE_I.idle
    |=> state_reg == RSC_RX)
    else $error("left receive despite stay select");

endmodule
`default_nettype wire

/* rtl/rsc_rx_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module rsc_rx_fifo
  import rsc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEF,
  parameter int CW = $clog2(DEPTH) + 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic flush_i,
  input wire logic [3:0] thr_sel_i,
  output logic [7:0] rd_data_o,
  output logic [CW-1:0] count_o,
  output logic thr_o,
  output logic ovf_o,
  output logic empty_o
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (DEPTH < 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 64");
  end

  localparam int AW = $clog2(DEPTH);

  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [7:0] rd_data_reg;
  logic ovf_reg;
  logic full;
  logic rd_ok;
  logic wr_ok;
  logic [CW-1:0] thr_bytes;

  // Read past empty is ignored, data holds
  assign full = (count_reg == CW'(DEPTH));
  assign rd_ok = rd_en_i && (count_reg != '0) && !flush_i;
  assign wr_ok = wr_valid_i && (!full || rd_ok) && !flush_i;
  assign thr_bytes = CW'({thr_sel_i, 2'b00}) + CW'(FILL_THRESHOLD_SELECT_STEP);

  // Storage
  always_ff @(posedge clk_i) begin
    if (wr_ok) begin
      mem[wr_ptr_reg] <= wr_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (wr_ok) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (rd_ok) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      // Simultaneous write and read keep the count
      if (wr_ok && !rd_ok) begin
        count_reg <= count_reg + CW'(1);
      end else if (rd_ok && !wr_ok) begin
        count_reg <= count_reg - CW'(1);
      end
    end
  end

  // Read data
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_reg <= 8'h00;
    end else if (rd_ok) begin
      rd_data_reg <= mem[rd_ptr_reg];
    end
  end

  // Sticky overflow, set wins over flush
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf_reg <= 1'b0;
    end else if (wr_valid_i && full && !rd_ok) begin
      ovf_reg <= 1'b1;
    end else if (flush_i) begin
      ovf_reg <= 1'b0;
    end
  end

  assign rd_data_o = rd_data_reg;
  assign count_o = count_reg;
  assign thr_o = (count_reg >= thr_bytes);
  assign ovf_o = ovf_reg;
  assign empty_o = (count_reg == '0);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_count_up: assert property (wr_valid_i && !full && !rd_en_i && !flush_i
    |=> count_reg == $past(count_reg) + CW'(1))
    else $error("fill count did not rise on write");
  a_ovf_sticky: assert property (ovf_reg && !flush_i |=> ovf_reg)
    else $error("overflow cleared without flush");
  a_thr_level: assert property (thr_o == (int'(count_reg) >=
    FILL_THRESHOLD_SELECT_STEP * (int'(thr_sel_i) + 1)))
    else $error("threshold signal wrong");

endmodule
`default_nettype wire
